// ### mon_pkg.sv
// Purpose: shared constants and types for the write-monitor serial port
// Assumes: 100 MHz system clock on both ends
// Notes: frame layout and link timing live here
package mon_pkg;
    localparam int FRAME_BITS = 21;           // bits per frame
    localparam int CNT_W = 5;                 // frame bit counter width
    localparam int DATA_ADDR_W = 16;          // watched data address width
    localparam int CODE_ADDR_W = 18;          // trigger code address width
    localparam int WORD_W = 16;               // captured word width
    localparam int MODE_BIT = 18;             // frame type select
    localparam int STORE_BIT = 19;            // store address into buffer
    localparam int RUN_BIT = 20;              // start or stop monitoring
    localparam logic [CNT_W-1:0] LAST_BIT = 5'h14; // index of final bit
    localparam logic [FRAME_BITS-1:0] FRAME_RST = 21'h000000; // cleared frame
    localparam int LINK_PERIOD_NS = 125;      // host link clock period
    localparam int SYS_PERIOD_NS = 10;        // system clock period
    // half link period in system cycles, rounded down
    localparam int HALF_CYC = (LINK_PERIOD_NS / 2) / SYS_PERIOD_NS;
    localparam int DIV_W = 4;                 // divider counter width
    localparam logic [DIV_W-1:0] HALF_CNT = DIV_W'(HALF_CYC - 1); // divider reload
endpackage

// ### mon_link_if.sv
// Purpose: link between debug host and monitor device
// Assumes: both ends run on clk_sys; serial clock is a sampled data pin
// Notes: all link signals are single-direction
`timescale 1ns/100ps
`default_nettype none
interface mon_link_if;
    logic monitorSerialClock; // host shift clock
    logic monitorSerialIn;    // host to device frame bits
    logic monitorSerialOut;   // device to host readout bits
    logic matchAcknowledge;   // device readout pending
    logic monitorModePin;     // monitor enable level
    // device end
    modport device (
        input monitorSerialClock, monitorSerialIn, monitorModePin,
        output monitorSerialOut, matchAcknowledge
    );
    // host end
    modport host (
        output monitorSerialClock, monitorSerialIn, monitorModePin,
        input monitorSerialOut, matchAcknowledge
    );
endinterface
`default_nettype wire

// ### sync_edge.sv
// Purpose: two-flop synchroniser for one pin with edge detect
// Assumes: pin is asynchronous to clk_sys
// Notes: edges are taken between second and third flop only
`timescale 1ns/100ps
`default_nettype none
module sync_edge
    import mon_pkg::*;
#(
    parameter logic RST_VAL = 1'b0 // idle level of the pin
) (
    input wire logic clk_sys, // system clock
    input wire logic rst,     // async reset, active high
    input wire logic pinIn,   // raw pin
    output logic levelOut,    // synchronised level
    output logic riseOut,     // one-cycle rising pulse
    output logic fallOut      // one-cycle falling pulse
);
    typedef struct packed {
        logic meta;  // first stage, read only by stage two
        logic sync;  // second stage
        logic prev;  // history for edges
    } state_t;
    state_t s_q;   // registered state
    state_t s_d;   // next state

    // shift the pin through the chain
    always_comb
    begin
        s_d = s_q;
        s_d.meta = pinIn;
        s_d.sync = s_q.meta;
        s_d.prev = s_q.sync;
    end

    // state register
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            s_q <= '{meta: RST_VAL, sync: RST_VAL, prev: RST_VAL};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign levelOut = s_q.sync;
    assign riseOut = s_q.sync & ~s_q.prev;
    assign fallOut = ~s_q.sync & s_q.prev;
endmodule
`default_nettype wire

// ### mon_device.sv
// Purpose: device end of the data-write monitor serial port
// Assumes: cpu write and program counter ports are on clk_sys
// Notes: core reset/stop/halt are not inputs; only rst and mode pin clear it
//   link clock and data are sampled pins, so each edge is seen about three
//   clk_sys cycles late; the host's half period leaves room for that lag
//   the readout word is loaded as acknowledge rises, so a hit in mid-frame
//   sends part of the word in that frame; the host should read between frames
//   acknowledge drops at the end of whichever frame follows its rise
//   a write and a frame end in one cycle: the write is kept (set wins)
//   a hit and a run frame end in one cycle: the hit wins and disarms
//   bits 16-17 of a data-address frame are ignored, not checked
//
`timescale 1ns/100ps
`default_nettype none
module mon_device
    import mon_pkg::*;
(
    input wire logic clk_sys,               // system clock
    input wire logic rst,                   // async reset, active high
    mon_link_if.device link,                // serial link to host
    input wire logic cpuWrite,              // cpu data write strobe
    input wire logic [DATA_ADDR_W-1:0] cpuWriteAddr, // cpu write address
    input wire logic [WORD_W-1:0] cpuWriteData, // cpu write data
    input wire logic [CODE_ADDR_W-1:0] progCounter, // current program counter
    output logic monitorActive              // comparison armed
);
    typedef struct packed {
        logic [FRAME_BITS-1:0] rxShift;   // incoming frame
        logic [FRAME_BITS-1:0] txShift;   // outgoing frame
        logic [CNT_W-1:0] bitCnt;         // bits taken this frame
        logic [DATA_ADDR_W-1:0] dataAddr; // watched data address
        logic [CODE_ADDR_W-1:0] codeAddr; // trigger code address
        logic [WORD_W-1:0] captured;      // captured word
        logic captureValid;               // a write was seen since arming
        logic armed;                      // comparing addresses
        logic ack;                        // acknowledge output
        logic txBit;                      // serial output bit
        logic modeSync1;                  // mode pin first stage
        logic modeSync2;                  // mode pin second stage
    } state_t;
    state_t s_q;  // registered state
    state_t s_d;  // next state
    logic clkLevel; // synchronised link clock
    logic clkRise;  // link clock rising
    logic clkFall;  // link clock falling
    logic rxLevel;  // synchronised serial input
    logic [FRAME_BITS-1:0] frame; // completed frame view
    logic writeHit; // cpu write to the watched address while armed
    logic matchHit; // program counter hit that raises acknowledge

    // readout frame: word in the low bits, pad bits driven zero
    function automatic logic [FRAME_BITS-1:0] readoutFrame(input logic [WORD_W-1:0] word);
        return {5'h00, word};
    endfunction

    // link clock and data pins pass two flops each
    sync_edge #(.RST_VAL(1'b1)) syncClk (
        .clk_sys(clk_sys),
        .rst(rst),
        .pinIn(link.monitorSerialClock),
        .levelOut(clkLevel),
        .riseOut(clkRise),
        .fallOut(clkFall)
    );
    // data pin idles high like the clock, so reset makes no false edge
    sync_edge #(.RST_VAL(1'b1)) syncRx (
        .clk_sys(clk_sys),
        .rst(rst),
        .pinIn(link.monitorSerialIn),
        .levelOut(rxLevel),
        .riseOut(),
        .fallOut()
    );

    // frame as it will stand after the final bit is shifted in
    assign frame = {rxLevel, s_q.rxShift[FRAME_BITS-1:1]};

    // a write only counts while comparison is armed; writes elsewhere
    // or while stopped leave the captured word alone
    assign writeHit = s_q.armed && cpuWrite && (cpuWriteAddr == s_q.dataAddr);
    // a pc hit before any capture since arming is ignored, so a stale
    // word from an earlier watch is never reported
    assign matchHit = s_q.armed && s_q.captureValid && (progCounter == s_q.codeAddr);

    // next-state logic
    always_comb
    begin
        s_d = s_q;
        s_d.modeSync1 = link.monitorModePin;
        s_d.modeSync2 = s_q.modeSync1;
        if (!s_q.modeSync2)
        begin
            // everything cleared while disabled; lines assumed idle high
            s_d.rxShift = FRAME_RST;
            s_d.txShift = FRAME_RST;
            s_d.bitCnt = '0;
            s_d.dataAddr = '0;
            s_d.codeAddr = '0;
            s_d.captured = '0;
            s_d.captureValid = 1'b0;
            s_d.armed = 1'b0;
            s_d.ack = 1'b0;
            s_d.txBit = 1'b0;
        end
        else
        begin
            // output changes on falling link edge
            if (clkFall)
            begin
                s_d.txBit = s_q.txShift[0];
                s_d.txShift = {1'b0, s_q.txShift[FRAME_BITS-1:1]};
            end
            // input sampled on rising link edge, in step with output
            if (clkRise)
            begin
                s_d.rxShift = frame;
                if (s_q.bitCnt == LAST_BIT)
                begin
                    s_d.bitCnt = '0;
                    // readout finished with this frame
                    s_d.ack = 1'b0;
                    if (frame[STORE_BIT])
                    begin
                        if (frame[MODE_BIT])
                        begin
                            s_d.codeAddr = frame[CODE_ADDR_W-1:0];
                        end
                        else
                        begin
                            // bits 16-17 expected zero and ignored
                            s_d.dataAddr = frame[DATA_ADDR_W-1:0];
                        end
                    end
                    // run bit arms or re-arms, zero stops
                    s_d.armed = frame[RUN_BIT];
                    // each arming waits for a fresh write
                    s_d.captureValid = 1'b0;
                end
                else
                begin
                    s_d.bitCnt = s_q.bitCnt + 5'h01;
                end
            end
            // the sets below come last so that they win over the clears above
            if (writeHit)
            begin
                // newest write to the watched address wins
                s_d.captured = cpuWriteData;
                s_d.captureValid = 1'b1;
            end
            // pc hit after a capture raises acknowledge and disarms
            if (matchHit)
            begin
                s_d.ack = 1'b1;
                // a run frame ending in this cycle is overridden; the host sees
                // the acknowledge and re-arms with the readout frame
                s_d.armed = 1'b0;
                // word enters the output path as ack rises; a fall in the same
                // cycle has already sent the old bit, so nothing is lost
                s_d.txShift = readoutFrame(s_q.captured);
            end
        end
    end

    // state register; core reset is not an input here
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // outputs come straight from the state register
    assign link.monitorSerialOut = s_q.txBit;
    assign link.matchAcknowledge = s_q.ack;
    assign monitorActive = s_q.armed;
endmodule
`default_nettype wire

// ### mon_host.sv
// Purpose: debug host end: drives link clock and frames, reads readout
// Assumes: user issues one frame at a time via sendFrame
// Notes: link clock derived by divider from clk_sys
`timescale 1ns/100ps
`default_nettype none
module mon_host
    import mon_pkg::*;
(
    input wire logic clk_sys,                   // system clock
    input wire logic rst,                       // async reset, active high
    mon_link_if.host link,                      // serial link to device
    input wire logic enable,                    // monitor mode request
    input wire logic sendFrame,                 // start a frame, one pulse
    input wire logic [FRAME_BITS-1:0] txFrame,  // frame to send
    output logic busy,                          // frame in progress
    output logic frameDone,                     // frame finished pulse
    output logic [WORD_W-1:0] readWord,         // word from last frame
    output logic ackSeen                        // synchronised acknowledge
);
    typedef enum logic [1:0] {
        IDLE = 2'b00,
        LOW  = 2'b01,
        HIGH = 2'b10
    } phase_t;
    typedef struct packed {
        phase_t phase;                 // link clock phase
        logic [DIV_W-1:0] div;         // half-period divider
        logic [CNT_W-1:0] bitCnt;      // bits sent
        logic [FRAME_BITS-1:0] txSh;   // frame being sent
        logic [FRAME_BITS-1:0] rxSh;   // readout being gathered
        logic sclk;                    // link clock out
        logic sdo;                     // link data out
        logic mode;                    // mode pin out
        logic done;                    // frame done pulse
        logic [WORD_W-1:0] word;       // last readout
        logic ackM;                    // ack first stage
        logic ackS;                    // ack second stage
        logic rxM;                     // readout first stage
        logic rxS;                     // readout second stage
        logic busy;                    // frame in progress, registered
    } state_t;
    state_t s_q;  // registered state
    state_t s_d;  // next state

    // link sequencer; lines rest high so enabling meets the idle-high need
    always_comb
    begin
        s_d = s_q;
        s_d.done = 1'b0;
        s_d.mode = enable;
        s_d.ackM = link.matchAcknowledge;
        s_d.ackS = s_q.ackM;
        s_d.rxM = link.monitorSerialOut;
        s_d.rxS = s_q.rxM;
        unique case (s_q.phase)
            IDLE:
            begin
                s_d.sclk = 1'b1;
                s_d.sdo = 1'b1;
                if (sendFrame && s_q.mode)
                begin
                    s_d.txSh = txFrame;
                    // data-address frames carry zero in the dummy bits
                    if (!txFrame[MODE_BIT])
                    begin
                        s_d.txSh[CODE_ADDR_W-1:DATA_ADDR_W] = '0;
                    end
                    s_d.bitCnt = '0;
                    s_d.div = HALF_CNT;
                    s_d.sclk = 1'b0;
                    s_d.sdo = txFrame[0];
                    s_d.phase = LOW;
                end
            end
            LOW:
            begin
                if (s_q.div == '0)
                begin
                    // rising edge: device samples, host samples readout
                    s_d.sclk = 1'b1;
                    s_d.rxSh = {s_q.rxS, s_q.rxSh[FRAME_BITS-1:1]};
                    s_d.div = HALF_CNT;
                    s_d.phase = HIGH;
                end
                else
                begin
                    s_d.div = s_q.div - 4'h1;
                end
            end
            HIGH:
            begin
                if (s_q.div == '0)
                begin
                    if (s_q.bitCnt == LAST_BIT)
                    begin
                        s_d.word = s_q.rxSh[WORD_W-1:0];
                        s_d.done = 1'b1;
                        s_d.sdo = 1'b1;
                        s_d.phase = IDLE;
                    end
                    else
                    begin
                        // falling edge: next bit out, lsb first
                        s_d.sclk = 1'b0;
                        s_d.txSh = {1'b0, s_q.txSh[FRAME_BITS-1:1]};
                        s_d.sdo = s_q.txSh[1];
                        s_d.bitCnt = s_q.bitCnt + 5'h01;
                        s_d.div = HALF_CNT;
                        s_d.phase = LOW;
                    end
                end
                else
                begin
                    s_d.div = s_q.div - 4'h1;
                end
            end
            default:
            begin
                s_d.phase = IDLE;
            end
        endcase
        // busy leaves a flip-flop like every other output
        s_d.busy = (s_d.phase != IDLE);
    end

    // state register
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            s_q <= '{phase: IDLE, div: '0, bitCnt: '0, txSh: '0, rxSh: '0,
                     sclk: 1'b1, sdo: 1'b1, mode: 1'b0, done: 1'b0, word: '0,
                     ackM: 1'b0, ackS: 1'b0, rxM: 1'b0, rxS: 1'b0, busy: 1'b0};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign link.monitorSerialClock = s_q.sclk;
    assign link.monitorSerialIn = s_q.sdo;
    assign link.monitorModePin = s_q.mode;
    assign busy = s_q.busy;
    assign frameDone = s_q.done;
    assign readWord = s_q.word;
    assign ackSeen = s_q.ackS;
endmodule
`default_nettype wire

// ### mon_chk.sv
// Purpose: wire-level checks on the link between host and device ends
// Assumes: all link signals are sampled on clk_sys
// Notes: bit position is rebuilt from raw link clock edges, not from design state
`timescale 1ns/100ps
`default_nettype none
module mon_chk (
    input wire logic clk_sys,            // system clock
    input wire logic rst,                // async reset, active high
    input wire logic monitorSerialClock, // link clock
    input wire logic monitorSerialIn,    // host data
    input wire logic monitorSerialOut,   // device data
    input wire logic matchAcknowledge,   // readout pending
    input wire logic monitorModePin      // monitor enable
);
    logic clkQ;        // last link clock level
    logic [4:0] fallQ; // falls seen in current frame, 1..21
    logic [4:0] riseQ; // rises modulo frame length
    // counters restart while disabled so each enable begins on a frame edge
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst || !monitorModePin)
        begin
            clkQ <= 1'b1;
            fallQ <= 5'h00;
            riseQ <= 5'h00;
        end
        else
        begin
            clkQ <= monitorSerialClock;
            if (clkQ && !monitorSerialClock)
                fallQ <= (fallQ == 5'h15) ? 5'h01 : fallQ + 5'h01;
            if (!clkQ && monitorSerialClock)
                riseQ <= (riseQ == 5'h14) ? 5'h00 : riseQ + 5'h01;
        end
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    a_low_phase: assert property ($fell(monitorSerialClock) |->
        (!monitorSerialClock)[*6] ##1 monitorSerialClock) else $error("link low phase wrong");
    a_high_phase: assert property ($rose(monitorSerialClock) |->
        monitorSerialClock[*6]) else $error("link high phase too short");
    a_sample_stable: assert property ($rose(monitorSerialClock) |->
        $stable(monitorSerialIn)) else $error("host data moved at rising edge");
    a_out_on_low: assert property (monitorModePin && $changed(monitorSerialOut) |->
        !monitorSerialClock) else $error("device data moved while clock high");
    a_pad_zero: assert property ($rose(monitorSerialClock) && fallQ > 5'h10 |->
        !monitorSerialOut) else $error("readout pad bit not zero");
    a_ack_at_end: assert property (monitorModePin && $fell(matchAcknowledge) |->
        riseQ == 5'h00 && monitorSerialClock) else $error("ack dropped mid frame");
    a_disabled_clear: assert property ((!monitorModePin)[*4] |->
        !matchAcknowledge && !monitorSerialOut) else $error("device active while disabled");
    a_idle_enable: assert property ($rose(monitorModePin) |->
        monitorSerialClock && monitorSerialIn) else $error("lines low at enable");
endmodule
`default_nettype wire

// ### tb_top.sv
// Purpose: host and device ends joined back to back, user sides driven
// Assumes: one frame at a time, inputs driven by nonblocking at rising edge
// Notes: readout bits are gathered from the wire at each rising link clock
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin errors++; \
    $display("BAD %s exp %0h got %0h", nm, ex, gt); end end
module tb_top
    import mon_pkg::*;
;
    logic clk_sys = 1'b0; // system clock
    logic rst = 1'b1; // reset
    logic enable = 1'b0; // mode request
    logic sendFrame = 1'b0; // frame start pulse
    logic cpuWrite = 1'b0; // cpu write strobe
    logic [FRAME_BITS-1:0] txFrame = '0; // frame to send
    logic [DATA_ADDR_W-1:0] cpuWriteAddr = '0; // write address
    logic [WORD_W-1:0] cpuWriteData = '0; // write data
    logic [CODE_ADDR_W-1:0] progCounter = '1; // idle value never used as trigger
    logic busy, frameDone, ackSeen, monitorActive; // design flags
    logic [WORD_W-1:0] readWord; // host readout, scored at frame end
    int errors = 0; // mismatches
    int num_checks = 0; // comparisons
    logic [31:0] seed = 32'hE6A17C46; // xorshift state
    logic [FRAME_BITS-1:0] notes[$]; // expected readout frames
    logic [FRAME_BITS-1:0] rxSh = '0; // bits seen on the wire
    logic clkQ = 1'b1; // last link clock level
    always #(SYS_PERIOD_NS / 2) clk_sys = ~clk_sys;
    mon_link_if mon_link_if_inst ();
    mon_host mon_host_inst (.clk_sys(clk_sys), .rst(rst), .link(mon_link_if_inst),
        .enable(enable), .sendFrame(sendFrame), .txFrame(txFrame), .busy(busy),
        .frameDone(frameDone), .readWord(readWord), .ackSeen(ackSeen));
    mon_device mon_device_inst (.clk_sys(clk_sys), .rst(rst), .link(mon_link_if_inst),
        .cpuWrite(cpuWrite), .cpuWriteAddr(cpuWriteAddr), .cpuWriteData(cpuWriteData),
        .progCounter(progCounter), .monitorActive(monitorActive));
    mon_chk mon_chk_inst (.clk_sys(clk_sys), .rst(rst),
        .monitorSerialClock(mon_link_if_inst.monitorSerialClock),
        .monitorSerialIn(mon_link_if_inst.monitorSerialIn),
        .monitorSerialOut(mon_link_if_inst.monitorSerialOut),
        .matchAcknowledge(mon_link_if_inst.matchAcknowledge),
        .monitorModePin(mon_link_if_inst.monitorModePin));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [FRAME_BITS-1:0] fr(input logic run, input logic store,
        input logic mode, input logic [CODE_ADDR_W-1:0] adr);
        return {run, store, mode, adr};
    endfunction
    // waits end on the falling edge so design outputs are settled
    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    // one frame; the readout it should carry is noted first
    task automatic send(input logic [FRAME_BITS-1:0] f, input logic [WORD_W-1:0] ex);
        int n;
        notes.push_back({5'h00, ex});
        @(posedge clk_sys);
        sendFrame <= 1'b1;
        txFrame <= f;
        @(posedge clk_sys);
        sendFrame <= 1'b0;
        n = 0;
        while (frameDone !== 1'b1 && n < 1000)
        begin
            tick(1);
            n++;
        end
        if (n >= 1000)
        begin
            // a frame that never ends is a mismatch
            errors++;
            end_of_test();
        end
        tick(3);
    endtask
    task automatic wr(input logic [DATA_ADDR_W-1:0] a, input logic [WORD_W-1:0] d);
        @(posedge clk_sys);
        cpuWrite <= 1'b1;
        cpuWriteAddr <= a;
        cpuWriteData <= d;
        @(posedge clk_sys);
        cpuWrite <= 1'b0;
        tick(1);
    endtask
    // one-cycle program counter hit, then room for the ack to land
    task automatic pc(input logic [CODE_ADDR_W-1:0] v);
        @(posedge clk_sys);
        progCounter <= v;
        @(posedge clk_sys);
        progCounter <= '1;
        tick(3);
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // gathers device bits at each rising link clock, scores at frame end
    always @(posedge clk_sys)
    begin
        clkQ <= mon_link_if_inst.monitorSerialClock;
        if (!clkQ && mon_link_if_inst.monitorSerialClock)
            rxSh <= {mon_link_if_inst.monitorSerialOut, rxSh[FRAME_BITS-1:1]};
        if (frameDone === 1'b1 && notes.size() > 0)
        begin
            `CHK("readout", notes[0], rxSh)
            `CHK("readWord", notes[0][WORD_W-1:0], readWord)
            void'(notes.pop_front());
        end
    end
    // a hang counts as a mismatch
    initial
    begin
        #200000;
        errors++;
        end_of_test();
    end
    initial
    begin
        logic [DATA_ADDR_W-1:0] a, a2;
        logic [CODE_ADDR_W-1:0] c, c2;
        logic [WORD_W-1:0] w1, w2;
        a = 16'(rnd());
        a2 = a ^ 16'h8000;
        c = {1'b0, 17'(rnd())};
        c2 = c ^ 18'h10000;
        w1 = 16'(rnd());
        w2 = 16'(rnd());
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        enable <= 1'b1;
        tick(4);
        send(fr(1'b0, 1'b1, 1'b0, {2'b00, a}), 16'h0000);
        send(fr(1'b1, 1'b1, 1'b1, c), 16'h0000);
        `CHK("armed", 1'b1, monitorActive)
        pc(c);
        `CHK("early ack", 1'b0, mon_link_if_inst.matchAcknowledge)
        wr(a, w1);
        wr(a ^ 16'h0001, 16'(rnd()));
        wr(a, w2);
        pc(c);
        `CHK("ack", 1'b1, mon_link_if_inst.matchAcknowledge)
        `CHK("disarmed", 1'b0, monitorActive)
        tick(4);
        `CHK("ackSeen", 1'b1, ackSeen)
        send(fr(1'b1, 1'b0, 1'b0, 18'(rnd())), w2);
        `CHK("ack end", 1'b0, mon_link_if_inst.matchAcknowledge)
        `CHK("rearmed", 1'b1, monitorActive)
        `CHK("busy", 1'b0, busy)
        $display("test capture and rearm done");
        send(fr(1'b0, 1'b1, 1'b1, c2), 16'h0000);
        send(fr(1'b1, 1'b1, 1'b0, {2'b00, a2}), 16'h0000);
        wr(a2, w1);
        pc(c2);
        `CHK("ack swapped", 1'b1, mon_link_if_inst.matchAcknowledge)
        send(fr(1'b0, 1'b0, 1'b0, 18'(rnd())), w1);
        `CHK("stopped", 1'b0, monitorActive)
        wr(a2, w2);
        pc(c2);
        `CHK("ack stopped", 1'b0, mon_link_if_inst.matchAcknowledge)
        $display("test order and stop done");
        send(fr(1'b1, 1'b0, 1'b0, {2'b00, a}), 16'h0000);
        wr(a, w2);
        pc(c2);
        `CHK("ack kept", 1'b0, mon_link_if_inst.matchAcknowledge)
        wr(a2, w1);
        pc(c2);
        `CHK("ack old addr", 1'b1, mon_link_if_inst.matchAcknowledge)
        $display("test store bit done");
        @(posedge clk_sys);
        enable <= 1'b0;
        tick(6);
        `CHK("ack off", 1'b0, mon_link_if_inst.matchAcknowledge)
        `CHK("armed off", 1'b0, monitorActive)
        @(posedge clk_sys);
        enable <= 1'b1;
        tick(4);
        send(fr(1'b1, 1'b0, 1'b0, 18'(rnd())), 16'h0000);
        wr(16'h0000, w2);
        pc(18'h00000);
        `CHK("ack zero addr", 1'b1, mon_link_if_inst.matchAcknowledge)
        send(fr(1'b0, 1'b0, 1'b0, 18'(rnd())), w2);
        $display("test mode pin done");
        end_of_test();
    end
endmodule
`default_nettype wire
